/* File: hdl/ssp_pkg.sv */
// Package for the SPI host/client serial port: register map, fields, timing.
// Assumes a 32-bit APB slave with one aligned word per register.
package ssp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD = 8'h10;
  localparam logic [7:0] ADDR_PINS = 8'h14;
  // Status register fields
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_EDGE_BIT = 6;
  localparam int STAT_PHASE_BIT = 7;
  // Control register one fields
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_COLL_BIT = 7;
  localparam int CTRL_IFLAG_BIT = 6;
  // Control register three fields
  localparam int CTRL3_OVR_BIT = 4;
  // Mode codes in control register one bits 3:0
  localparam logic [3:0] MODE_HOST_DIV4 = 4'h0;
  localparam logic [3:0] MODE_HOST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_HOST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_HOST_TIMER = 4'h3;
  localparam logic [3:0] MODE_CLIENT_SEL = 4'h4;
  localparam logic [3:0] MODE_CLIENT_NOSEL = 4'h5;
  localparam logic [3:0] MODE_HOST_RELOAD = 4'ha;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Oscillator cycles per host bit-rate unit
  localparam int OSC_PER_UNIT = 4;
  localparam int BITS_PER_WORD = 8;
endpackage : ssp_pkg

/* File: hdl/ssp_port.sv */
// SPI host/client serial port with APB register access.
// Assumes serial pins and timer tick arrive asynchronously; APB on clock_in.
`timescale 1ns/1ps
`default_nettype none
module ssp_port #(
  parameter int OSC_DIV = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  input wire logic sel_n_in,
  // Timer tick and wake
  input wire logic timer_tick_in,
  output logic wake_out
);
  initial begin
    if (OSC_DIV < 1) $error("OSC_DIV must be at least 1");
  end

  typedef struct packed {
    logic [7:0] stat_cfg;
    logic [7:0] ctrl;
    logic [7:0] ctrl3;
    logic [7:0] rxbuf;
    logic [7:0] reload;
    logic [7:0] pins;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic busy;
    logic full;
    logic coll;
    logic iflag;
    logic [15:0] divcnt;
    logic sck_int;
    logic sdo_q;
    logic inbit;
    logic [2:0] sck_s;
    logic [1:0] sdi_s;
    logic [1:0] sel_s;
    logic [2:0] tmr_s;
    logic tmr_half;
    logic [31:0] rdata;
    logic ack;
    logic lead_d;
  } ssp_state_s;

  ssp_state_s st_q;
  ssp_state_s st_d;

  function automatic logic [15:0] ssp_div(input logic [3:0] m, input logic [7:0] r);
    logic [15:0] u;
    u = 16'h0001;
    if (m == ssp_pkg::MODE_HOST_DIV16) u = 16'h0004;
    else if (m == ssp_pkg::MODE_HOST_DIV64) u = 16'h0010;
    else if (m == ssp_pkg::MODE_HOST_RELOAD) u = {8'h00, r} + 16'h0001;
    ssp_div = 16'((32'(u) * 32'(ssp_pkg::OSC_PER_UNIT) * 32'(OSC_DIV)) / 2);
  endfunction : ssp_div

  logic [3:0] mode;
  logic en;
  logic host;
  logic pol;
  logic cke;
  logic acc;
  logic acc_first;
  logic sck_rise;
  logic sck_fall;
  logic sel_ok;

  assign mode = st_q.ctrl[3:0];
  assign en = st_q.ctrl[ssp_pkg::CTRL_ENABLE_BIT];
  assign host = (mode == ssp_pkg::MODE_HOST_DIV4) || (mode == ssp_pkg::MODE_HOST_DIV16) ||
                (mode == ssp_pkg::MODE_HOST_DIV64) || (mode == ssp_pkg::MODE_HOST_TIMER) ||
                (mode == ssp_pkg::MODE_HOST_RELOAD);
  assign pol = st_q.ctrl[ssp_pkg::CTRL_POL_BIT];
  assign cke = st_q.stat_cfg[ssp_pkg::STAT_EDGE_BIT];
  // One wait state: read data is registered in the first access cycle
  assign acc = psel && penable && st_q.ack;
  assign acc_first = psel && penable && !st_q.ack;
  assign sck_rise = st_q.sck_s[1] && !st_q.sck_s[2];
  assign sck_fall = !st_q.sck_s[1] && st_q.sck_s[2];
  assign sel_ok = (mode != ssp_pkg::MODE_CLIENT_SEL) || !st_q.sel_s[1];

  always_comb begin
    logic tick;
    logic lead;
    logic trail;
    logic done;
    logic [7:0] nxt;
    st_d = st_q;
    tick = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    done = 1'b0;
    nxt = st_q.shreg;
    // Pin synchronisers
    st_d.sck_s = {st_q.sck_s[1:0], sck_in};
    st_d.sdi_s = {st_q.sdi_s[0], sdi_in};
    st_d.sel_s = {st_q.sel_s[0], sel_n_in};
    st_d.tmr_s = {st_q.tmr_s[1:0], timer_tick_in};
    st_d.rdata = 32'h0000_0000;
    st_d.ack = acc_first;
    // Host bit clock generation
    if (host && en && st_q.busy) begin
      if (mode == ssp_pkg::MODE_HOST_TIMER) begin
        if (st_q.tmr_s[1] && !st_q.tmr_s[2]) begin
          tick = 1'b1;
        end
      end else if (st_q.divcnt == 16'h0001 || st_q.divcnt == 16'h0000) begin
        tick = 1'b1;
        st_d.divcnt = ssp_div(mode, st_q.reload);
      end else begin
        st_d.divcnt = st_q.divcnt - 16'h0001;
      end
      if (tick) begin
        st_d.sck_int = !st_q.sck_int;
        lead = (st_q.sck_int == pol);
        trail = !lead;
      end
    end else if (!host && en && sel_ok) begin
      // Active edge leaves idle level; its opposite returns to idle
      lead = pol ? sck_fall : sck_rise;
      trail = pol ? sck_rise : sck_fall;
    end
    st_d.lead_d = lead;
    // Sampling on one edge, shifting out on the other
    if (cke) begin
      // Host samples one cycle late so the input synchroniser has caught up
      if (host ? st_q.lead_d : lead) st_d.inbit = st_q.sdi_s[1];
      if (trail) begin
        nxt = {st_q.shreg[6:0], st_q.inbit};
        st_d.bitcnt = st_q.bitcnt + 4'h1;
      end
    end else begin
      if (lead && st_q.bitcnt != 4'h0) begin
        nxt = {st_q.shreg[6:0], st_q.inbit};
      end
      if (trail) begin
        st_d.inbit = st_q.sdi_s[1];
        st_d.bitcnt = st_q.bitcnt + 4'h1;
      end
    end
    if (!cke && trail && st_q.bitcnt == 4'h7) begin
      nxt = {st_q.shreg[6:0], st_q.sdi_s[1]};
      done = 1'b1;
    end
    if (cke && trail && st_q.bitcnt == 4'h7) done = 1'b1;
    st_d.shreg = nxt;
    if (lead || trail) st_d.busy = 1'b1;
    st_d.sdo_q = nxt[7];
    if (done) begin
      st_d.bitcnt = 4'h0;
      st_d.busy = 1'b0;
      if (host) st_d.sck_int = pol;
      st_d.iflag = 1'b1;
      if (!st_q.full || st_q.ctrl3[ssp_pkg::CTRL3_OVR_BIT]) begin
        st_d.rxbuf = nxt;
      end
      st_d.full = 1'b1;
    end
    // APB access
    if (acc_first && !pwrite) begin
      unique case (paddr)
        ssp_pkg::ADDR_STATUS:
          st_d.rdata = {24'h0, st_q.stat_cfg[7:6], 5'h00, st_q.full};
        ssp_pkg::ADDR_CTRL_ONE:
          st_d.rdata = {24'h0, st_q.coll, st_q.iflag, st_q.ctrl[5:0]};
        ssp_pkg::ADDR_CTRL_THREE: st_d.rdata = {24'h0, st_q.ctrl3};
        ssp_pkg::ADDR_DATA: st_d.rdata = {24'h0, st_q.rxbuf};
        ssp_pkg::ADDR_RELOAD: st_d.rdata = {24'h0, st_q.reload};
        ssp_pkg::ADDR_PINS: st_d.rdata = {24'h0, st_q.pins};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && !pwrite && paddr == ssp_pkg::ADDR_DATA && !done) begin
      st_d.full = 1'b0;
    end
    if (acc && pwrite) begin
      unique case (paddr)
        ssp_pkg::ADDR_STATUS: st_d.stat_cfg = {pwdata[7:6], 6'h00};
        ssp_pkg::ADDR_CTRL_ONE: begin
          st_d.ctrl = {2'b00, pwdata[5:0]};
          if (!pwdata[ssp_pkg::CTRL_COLL_BIT]) st_d.coll = 1'b0;
          if (!pwdata[ssp_pkg::CTRL_IFLAG_BIT] && !done) st_d.iflag = 1'b0;
        end
        ssp_pkg::ADDR_CTRL_THREE: st_d.ctrl3 = pwdata[7:0];
        ssp_pkg::ADDR_DATA: begin
          if (st_q.busy || st_q.bitcnt != 4'h0) begin
            st_d.coll = 1'b1;
          end else if (!st_q.coll) begin
            st_d.shreg = pwdata[7:0];
            st_d.rxbuf = pwdata[7:0];
            st_d.sdo_q = pwdata[7];
            if (host) begin
              st_d.busy = 1'b1;
              st_d.divcnt = ssp_div(mode, st_q.reload);
            end
          end
        end
        ssp_pkg::ADDR_RELOAD: st_d.reload = pwdata[7:0];
        ssp_pkg::ADDR_PINS: st_d.pins = pwdata[7:0];
        default: st_d.pins = st_q.pins;
      endcase
    end
    // Port reset by enable clear, or by select high in MODE_CLIENT_SEL
    if (!en || (mode == ssp_pkg::MODE_CLIENT_SEL && st_q.sel_s[1])) begin
      st_d.bitcnt = 4'h0;
      st_d.busy = 1'b0;
      st_d.sck_int = pol;
      st_d.divcnt = 16'h0000;
    end
    if (host && !st_q.busy) st_d.sck_int = pol;
    if (!host) st_d.sck_int = pol;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs; pin direction bits: bit0 disables data out, bit1 disables clock out
  assign prdata = st_q.rdata;
  assign pready = st_q.ack;
  assign pslverr = 1'b0;
  assign sck_out = st_q.sck_int;
  assign sck_oe_out = en && host && !st_q.pins[1];
  assign sdo_out = st_q.sdo_q;
  assign sdo_oe_out = en && sel_ok && !st_q.pins[0];
  assign wake_out = st_q.iflag && !host;

  a_data_clears_full: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && !pwrite && paddr == ssp_pkg::ADDR_DATA && !st_d.iflag |=> !st_q.full)
    else $error("receive-full not cleared by data read");
  a_busy_write_coll: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && pwrite && paddr == ssp_pkg::ADDR_DATA && st_q.busy && en |=> st_q.coll)
    else $error("collision flag not set");
  a_coll_blocks: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && pwrite && paddr == ssp_pkg::ADDR_DATA && st_q.coll && !st_q.busy && en
    |=> $stable(st_q.rxbuf) || st_q.full)
    else $error("write accepted with collision set");
  a_host_starts: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && pwrite && paddr == ssp_pkg::ADDR_DATA && host && en && !st_q.busy && !st_q.coll
    |=> st_q.busy)
    else $error("host did not start");
  a_disable_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !en |=> st_q.bitcnt == 4'h0)
    else $error("bit counter not zero in reset");
  a_unsel_float: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    mode == ssp_pkg::MODE_CLIENT_SEL && st_q.sel_s[1] |-> !sdo_oe_out)
    else $error("output driven while deselected");
  a_done_flags: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st_q.bitcnt == 4'h7 && !st_d.busy && en && sel_ok && st_d.bitcnt == 4'h0 && st_q.busy
    |=> st_q.full && st_q.iflag)
    else $error("completion flags missing");
  a_idle_level: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !st_q.busy && $past(!st_q.busy) && en |-> sck_out == pol)
    else $error("clock not at idle level");
  a_write_loads: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && pwrite && paddr == ssp_pkg::ADDR_DATA && !st_q.busy && st_q.bitcnt == 4'h0 &&
    !st_q.coll |=> st_q.shreg == $past(pwdata[7:0]))
    else $error("data write did not load shift register");
  a_unsel_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    mode == ssp_pkg::MODE_CLIENT_SEL && st_q.sel_s[1] |=> st_q.bitcnt == 4'h0)
    else $error("bit counter not zero while deselected");
  a_unsel_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    mode == ssp_pkg::MODE_CLIENT_SEL && st_q.sel_s[1] |=> !st_q.busy)
    else $error("deselected client is shifting");
  a_off_no_drive: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !en |-> !sck_oe_out && !sdo_oe_out)
    else $error("pins driven while disabled");
  a_en_clear_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !en |=> !st_q.busy)
    else $error("port busy while disabled");
  a_sdo_override: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st_q.pins[0] |-> !sdo_oe_out)
    else $error("data output driven against direction");
  a_client_no_sck: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !host |-> !sck_oe_out)
    else $error("client drives clock");
  a_client_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !host && $stable(st_q.ctrl) |-> sck_out == pol)
    else $error("client clock output not idle");
  a_status_low_ro: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && pwrite && paddr == ssp_pkg::ADDR_STATUS |=> st_q.stat_cfg[5:0] == 6'h00)
    else $error("status low bits written");
  a_coll_sticky: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st_q.coll && !(acc && pwrite && paddr == ssp_pkg::ADDR_CTRL_ONE) |=> st_q.coll)
    else $error("collision flag lost");
  a_coll_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc && pwrite && paddr == ssp_pkg::ADDR_CTRL_ONE && !pwdata[7] |=> !st_q.coll)
    else $error("collision flag not cleared");
  a_full_keeps: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st_q.full && !st_q.ctrl3[ssp_pkg::CTRL3_OVR_BIT] &&
    !(acc && pwrite && paddr == ssp_pkg::ADDR_DATA) |=> $stable(st_q.rxbuf))
    else $error("unread buffer overwritten");
  a_bitcnt_range: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st_q.bitcnt <= 4'h7)
    else $error("bit counter beyond word");
  a_sdo_msb: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st_q.sdo_q == st_q.shreg[7])
    else $error("output bit is not shift register msb");
  a_one_wait: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    psel && penable && !pready |=> pready)
    else $error("bus answer late");
endmodule : ssp_port
`default_nettype wire

/* File: dv/ssp_client_model.sv */
// SPI client model on the pins of the port while it is host.
// Assumes idle-low clock, data out on falling and sampled on rising edge.
`timescale 1ns/1ps
`default_nettype none
module ssp_client_model (
  // Serial pins
  input wire logic sck_in,
  input wire logic sdi_in,
  output logic sdo_out,
  // Word to send and word taken
  input wire logic [7:0] tx_in,
  input wire logic load_in,
  output logic [7:0] rx_out
);
  logic [7:0] sh = 8'h00;
  assign sdo_out = sh[7];
  always @(posedge load_in) sh <= tx_in;
  always @(posedge sck_in) rx_out <= {rx_out[6:0], sdi_in};
  always @(negedge sck_in) sh <= {sh[6:0], 1'b0};
endmodule : ssp_client_model
`default_nettype wire

/* File: dv/ssp_port_tb.sv */
// Bench for the serial port: APB tasks, host exchanges, client frames.
// Assumes the client model on the pins while the port is host.
`timescale 1ns/1ps
`default_nettype none
module ssp_port_tb;
  logic clock_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, tx = 8'h00, crx, d, p, c, got;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, sck_out, sck_oe_out, sdo_out, sdo_oe_out, wake_out, csdo;
  logic bsck = 0, bsdi = 0, sel_n = 1, tick = 0, ld = 0, rd_v = 0, hm = 1;
  logic [31:0] q[$];
  logic [3:0] md[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
  int pr[5] = '{4, 16, 64, 16, 12};
  int error_cnt = 0, checks = 0, seed = 32'h315d179d, cyc = 0, last = 0, gap = 0;
  wire sck_w = sck_oe_out ? sck_out : bsck;
  ssp_port #(.OSC_DIV(1)) ssp_port_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out), .sdi_in(hm ? csdo : bsdi),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .sel_n_in(sel_n),
    .timer_tick_in(tick), .wake_out(wake_out));
  ssp_client_model ssp_client_model_inst (.sck_in(sck_w),
    .sdi_in(sdo_oe_out ? sdo_out : cyc[0]), .sdo_out(csdo), .tx_in(tx),
    .load_in(ld), .rx_out(crx));
  initial forever #2 clock_in = ~clock_in;
  always @(posedge clock_in) cyc++;
  always @(posedge clock_in) tick <= cyc[2];
  always @(posedge sck_w) begin
    gap = cyc - last;
    last = cyc;
  end
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic tmo();
    error_cnt++;
    conclude();
  endtask : tmo
  // Setup, then access held until pready is sampled high; read data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic k);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (n == 50) tmo();
    end while (pready !== 1'b1);
    rv = prdata;
    rd_v <= k;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
    rd_v <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 1'b0);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask : rdc
  always @(posedge clock_in) begin
    if (rd_v === 1'b1) check("prdata", rv, q.pop_front());
  end
  task automatic wfull();
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[ssp_pkg::STAT_FULL_BIT] !== 1'b1) begin
      bus(1'b0, ssp_pkg::ADDR_STATUS, 32'h0, 1'b0);
      n++;
      if (n == 400) tmo();
    end
  endtask : wfull
  task automatic hx(input logic [3:0] m, input int per, input logic off);
    d = $random(seed);
    p = $random(seed);
    tx <= p;
    ld <= 1'b1;
    wr(ssp_pkg::ADDR_CTRL_ONE, 32'h0);
    ld <= 1'b0;
    wr(ssp_pkg::ADDR_PINS, {31'h0, off});
    wr(ssp_pkg::ADDR_CTRL_ONE, {28'h2, m});
    wr(ssp_pkg::ADDR_DATA, {24'h0, d});
    wr(ssp_pkg::ADDR_DATA, {24'h0, ~d});
    check("sck drive", sck_oe_out, 1'b1);
    check("sdo drive", sdo_oe_out, !off);
    wfull();
    check("bit period", gap, per);
    if (!off) check("client rx", crx, d);
    rdc(ssp_pkg::ADDR_CTRL_ONE, {24'h0, 4'he, m});
    rdc(ssp_pkg::ADDR_DATA, {24'h0, p});
    rdc(ssp_pkg::ADDR_STATUS, 32'h40);
  endtask : hx
  // Bench as host: 32 ns serial clock, bits sampled before the falling edge
  task automatic frame(input int nb, input logic s, input logic [7:0] h);
    sel_n <= s;
    repeat (4) @(posedge clock_in);
    for (int i = 7; i > 7 - nb; i--) begin
      bsdi <= h[i];
      repeat (4) @(posedge clock_in);
      bsck <= 1'b1;
      repeat (4) @(posedge clock_in);
      got[i] = sdo_out;
      check("sdo drive", sdo_oe_out, !s);
      bsck <= 1'b0;
    end
    bsdi <= ~bsdi;
    repeat (8) @(posedge clock_in);
    sel_n <= 1'b1;
    repeat (8) @(posedge clock_in);
  endtask : frame
  initial begin
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rdc(ssp_pkg::ADDR_STATUS, 32'h0);
    rdc(ssp_pkg::ADDR_CTRL_ONE, 32'h0);
    rdc(8'h18, 32'h0);
    wr(ssp_pkg::ADDR_STATUS, 32'hff);
    rdc(ssp_pkg::ADDR_STATUS, 32'hc0);
    wr(ssp_pkg::ADDR_STATUS, 32'h40);
    wr(ssp_pkg::ADDR_RELOAD, 32'h2);
    for (int k = 0; k < 5; k++) hx(md[k], pr[k], k == 4);
    $display("host exchanges done");
    hm <= 1'b0;
    wr(ssp_pkg::ADDR_PINS, 32'h0);
    wr(ssp_pkg::ADDR_CTRL_ONE, 32'h0);
    bsck <= 1'b0;
    wr(ssp_pkg::ADDR_CTRL_ONE, 32'h24);
    c = $random(seed);
    d = $random(seed);
    p = $random(seed);
    wr(ssp_pkg::ADDR_DATA, {24'h0, c});
    frame(8, 1'b0, d);
    check("client out", got, c);
    check("wake", wake_out, 1'b1);
    rdc(ssp_pkg::ADDR_CTRL_ONE, 32'h64);
    frame(8, 1'b0, p);
    check("chain echo", got, d);
    rdc(ssp_pkg::ADDR_DATA, {24'h0, d});
    rdc(ssp_pkg::ADDR_STATUS, 32'h40);
    wr(ssp_pkg::ADDR_CTRL_THREE, 32'h10);
    frame(8, 1'b0, d);
    wr(ssp_pkg::ADDR_DATA, {24'h0, c});
    frame(8, 1'b0, p);
    check("overwrite out", got, c);
    bus(1'b0, ssp_pkg::ADDR_DATA, 32'h0, 1'b0);
    wr(ssp_pkg::ADDR_CTRL_ONE, 32'h24);
    check("wake clear", wake_out, 1'b0);
    frame(3, 1'b0, p);
    frame(8, 1'b0, d);
    rdc(ssp_pkg::ADDR_DATA, {24'h0, d});
    frame(8, 1'b1, p);
    rdc(ssp_pkg::ADDR_STATUS, 32'h40);
    $display("client frames done");
    conclude();
  end
endmodule : ssp_port_tb
`default_nettype wire
